// >>> design/lsmon_pkg.sv
// Types shared by the load/store block event monitor
package lsmon_pkg;

	typedef logic [47:0] count_t;
	typedef logic [7:0]  code_t;
	typedef logic [47:0] addr_t;
	typedef logic [4:0]  size_t;   // access width in bytes, 1..16

	typedef enum logic [1:0]
	{
		ORD_IDLE,
		ORD_WAIT_OBSERVE,
		ORD_WAIT_SNOOP
	} order_state_t;

endpackage

// >>> design/lsmon_regs.svh
// Constants for the load/store block event monitor
`ifndef LSMON_REGS_SVH
`define LSMON_REGS_SVH

// Event numbers
`define EVT_LOAD_BLOCK      8'h03
`define EVT_STORE_BLOCK     8'h04

// Unit masks
`define UM_OVERLAP          8'h08
`define UM_HELD_TO_RETIRE   8'h10
`define UM_DCACHE_BLOCKED   8'h20
`define UM_SB_DRAIN         8'h01
`define UM_STORE_ORDER      8'h02

// Geometry
`define PAGE_OFS_BITS       12
`define QWORD_OFS_BITS      3
`define LINE_OFS_BITS       6

// Outstanding data-cache miss limit
`define MISS_MAX            4'h8

// Counter reset value
`define COUNT_RESET         48'h0

`endif

// >>> design/lsmon_top.sv
// Load/store block event detection feeding one general-purpose counter
`timescale 1ns/1ns
`include "lsmon_regs.svh"
module lsmon_top
	import lsmon_pkg::*;
(
	// Clock and reset
	input  wire logic            CLK,
	input  wire logic            ARST_N,
	// Counter selection
	input  wire lsmon_pkg::code_t EVT_SEL,
	input  wire lsmon_pkg::code_t UMASK_SEL,
	input  wire logic            COUNT_EN,
	// Load being dispatched
	input  wire logic            LD_VALID,
	input  wire lsmon_pkg::addr_t LD_ADDR,
	input  wire lsmon_pkg::size_t LD_SIZE,
	input  wire logic            LD_UNCACHEABLE,
	input  wire logic            LD_PARTIAL_READ,
	// Older store it is checked against
	input  wire logic            ST_VALID,
	input  wire lsmon_pkg::addr_t ST_ADDR,
	input  wire lsmon_pkg::size_t ST_SIZE,
	input  wire logic            ST_RETIRED,
	input  wire logic            ST_COMMITTED,
	// Data cache state
	input  wire logic            MISS_ALLOC,
	input  wire logic            MISS_DONE,
	input  wire logic            LOCKED_LOAD,
	// Store pipeline state
	input  wire logic            DRAIN_SERIALIZE,
	input  wire logic            DRAIN_SYNC,
	input  wire logic            DRAIN_INT_ACK,
	input  wire logic            DRAIN_FLUSH,
	input  wire logic            STORE_ORDER_WAIT,
	input  wire logic            LINE_OBSERVED,
	input  wire logic            NEEDS_BUS_READ,
	input  wire logic            SNOOP_RESP,
	// Event levels and counter
	output logic                 LOAD_HOLD,
	output logic                 LOAD_OVERLAP_EVT,
	output logic                 LOAD_HELD_TO_RETIRE_EVT,
	output logic                 LOAD_DCACHE_BLOCKED_EVT,
	output logic                 STORE_BUFFER_DRAIN_EVT,
	output logic                 STORE_ORDER_EVT,
	output lsmon_pkg::count_t    COUNT
);
	import lsmon_pkg::*;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------

	// Access crosses a cache line
	function automatic logic line_split(addr_t a, size_t s);
		addr_t last;
		begin
			last = a + {43'h0, s} - 48'd1;
			line_split = a[47:`LINE_OFS_BITS] != last[47:`LINE_OFS_BITS];
		end
	endfunction

	// ---------------------------------------------------------------
	// Overlap detection and hold
	// ---------------------------------------------------------------

	logic overlap_hit;

	overlap_detect u_overlap
	(
		.ld_addr (LD_ADDR),
		.ld_size (LD_SIZE),
		.st_addr (ST_ADDR),
		.st_size (ST_SIZE),
		.blocked (overlap_hit)
	);

	logic overlap_now;
	logic hold;
	logic next_hold;

	assign overlap_now = LD_VALID && ST_VALID && overlap_hit;

	// Held until retire and commit; a new overlap re-arms the hold
	always_comb
	begin
		next_hold = hold;
		if (hold && ST_RETIRED && ST_COMMITTED)
			next_hold = 1'b0;
		if (overlap_now)
			next_hold = 1'b1;
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			hold <= 1'b0;
		else
			hold <= next_hold;
	end

	// ---------------------------------------------------------------
	// Outstanding data cache misses
	// ---------------------------------------------------------------

	// Every miss source arrives on MISS_ALLOC, so all count alike
	logic [3:0] misses;
	logic [3:0] next_misses;

	always_comb
	begin
		next_misses = misses;
		if (MISS_ALLOC && !MISS_DONE && misses != 4'hf)
			next_misses = misses + 4'h1;
		else if (MISS_DONE && !MISS_ALLOC && misses != 4'h0)
			next_misses = misses - 4'h1;
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			misses <= 4'h0;
		else
			misses <= next_misses;
	end

	// ---------------------------------------------------------------
	// Event conditions
	// ---------------------------------------------------------------

	logic ev_overlap;
	logic ev_retire;
	logic ev_dcache;
	logic ev_drain;
	logic ev_order;
	logic split;

	order_stall u_order
	(
		.clk            (CLK),
		.arst_n         (ARST_N),
		.store_wait     (STORE_ORDER_WAIT),
		.line_observed  (LINE_OBSERVED),
		.needs_bus_read (NEEDS_BUS_READ),
		.snoop_resp     (SNOOP_RESP),
		.stalled        (ev_order)
	);

	// Load events fire once per blocked dispatch attempt
	always_comb
	begin
		split = LD_VALID && line_split(LD_ADDR, LD_SIZE);
		ev_overlap = overlap_now;
		ev_retire = LD_VALID && (LD_UNCACHEABLE || split);
		ev_dcache = LD_VALID && ((misses >= `MISS_MAX)
			|| split
			|| LD_PARTIAL_READ || LOCKED_LOAD);
		ev_drain = DRAIN_SERIALIZE || DRAIN_SYNC
			|| DRAIN_INT_ACK || DRAIN_FLUSH;
	end

	// ---------------------------------------------------------------
	// Selection and counting
	// ---------------------------------------------------------------

	logic   hit;
	count_t count;
	count_t next_count;

	// Both codes must match; anything else selects nothing
	always_comb
	begin
		hit = 1'b0;
		case (EVT_SEL)
			`EVT_LOAD_BLOCK:
				case (UMASK_SEL)
					`UM_OVERLAP:        hit = ev_overlap;
					`UM_HELD_TO_RETIRE: hit = ev_retire;
					`UM_DCACHE_BLOCKED: hit = ev_dcache;
					default:            hit = 1'b0;
				endcase
			`EVT_STORE_BLOCK:
				case (UMASK_SEL)
					`UM_SB_DRAIN:       hit = ev_drain;
					`UM_STORE_ORDER:    hit = ev_order;
					default:            hit = 1'b0;
				endcase
			default:
				hit = 1'b0;
		endcase
		next_count = count;
		if (COUNT_EN && hit)
			next_count = count + 48'd1;
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			count <= `COUNT_RESET;
		else
			count <= next_count;
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------

	// Event levels are combinational views of this cycle; LOAD_HOLD and STORE_ORDER_EVT come from registers
	assign LOAD_HOLD               = hold;
	assign LOAD_OVERLAP_EVT        = ev_overlap;
	assign LOAD_HELD_TO_RETIRE_EVT = ev_retire;
	assign LOAD_DCACHE_BLOCKED_EVT = ev_dcache;
	assign STORE_BUFFER_DRAIN_EVT  = ev_drain;
	assign STORE_ORDER_EVT         = ev_order;
	assign COUNT                   = count;

endmodule

// >>> design/order_stall.sv
// Store ordering stall tracker
`timescale 1ns/1ns
module order_stall
	import lsmon_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// Store status
	input  wire logic store_wait,
	input  wire logic line_observed,
	input  wire logic needs_bus_read,
	input  wire logic snoop_resp,
	// Stall level
	output logic      stalled
);

	order_state_t state;
	order_state_t next_state;

	// A bus-read store waits for its snoop answer, not for observation
	always_comb
	begin
		next_state = state;
		case (state)
			ORD_IDLE:
				if (store_wait)
					next_state = needs_bus_read ? ORD_WAIT_SNOOP
						: ORD_WAIT_OBSERVE;
			ORD_WAIT_OBSERVE:
				if (line_observed)
					next_state = ORD_IDLE;
			ORD_WAIT_SNOOP:
				if (snoop_resp)
					next_state = ORD_IDLE;
			default:
				next_state = ORD_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			state <= ORD_IDLE;
		else
			state <= next_state;
	end

	assign stalled = (state != ORD_IDLE);
endmodule

// >>> design/overlap_detect.sv
// Overlap and aliasing checks of one load against one older store
`timescale 1ns/1ns
`include "lsmon_regs.svh"
module overlap_detect
	import lsmon_pkg::*;
(
	// Load
	input  wire addr_t ld_addr,
	input  wire size_t ld_size,
	// Older store
	input  wire addr_t st_addr,
	input  wire size_t st_size,
	// Result
	output logic       blocked
);

	// Aligned when address is a multiple of size
	function automatic logic is_aligned(addr_t a, size_t s);
		logic [4:0] m;
		begin
			m = s - 5'd1;
			is_aligned = ((a[4:0] & m) == 5'h00);
		end
	endfunction

	logic  touch;
	logic  same_page_ofs;
	logic  diff_page;
	addr_t ld_end;
	addr_t ld_last;
	addr_t st_end;

	// Byte ranges and page geometry
	always_comb
	begin
		ld_end = ld_addr + {43'h0, ld_size};
		ld_last = ld_end - 48'd1; // Last byte, so slices compare alike
		st_end = st_addr + {43'h0, st_size};
		touch = (ld_addr < st_end) && (st_addr < ld_end);
		same_page_ofs = ld_addr[`PAGE_OFS_BITS-1:0]
			== st_addr[`PAGE_OFS_BITS-1:0];
		diff_page = ld_addr[47:`PAGE_OFS_BITS]
			!= st_addr[47:`PAGE_OFS_BITS];
	end

	// Any of the blocking shapes
	always_comb
	begin
		blocked = 1'b0;
		if (touch && ld_size <= 5'd2 && ld_addr != st_addr)
			blocked = 1'b1;
		if (touch && !is_aligned(st_addr, st_size) && ld_addr != st_addr)
			blocked = 1'b1;
		if (ld_size != 5'd16 && ld_addr[47:`QWORD_OFS_BITS]
			!= ld_last[47:`QWORD_OFS_BITS])
			blocked = 1'b1;
		if (same_page_ofs && diff_page)
			blocked = 1'b1;
	end

endmodule

// >>> dv/lsmon_top_assertions.sv
// Concurrent checks on the ports of the load/store event monitor
`timescale 1ns/1ns
module lsmon_assertions
	import lsmon_pkg::*;
(
	// Clock and reset
	input wire logic              CLK,
	input wire logic              ARST_N,
	// Selection and causes
	input wire lsmon_pkg::code_t  EVT_SEL,
	input wire lsmon_pkg::code_t  UMASK_SEL,
	input wire logic              COUNT_EN,
	input wire logic              ST_COMMITTED,
	input wire logic              DRAIN_SERIALIZE,
	input wire logic              DRAIN_SYNC,
	input wire logic              DRAIN_INT_ACK,
	input wire logic              DRAIN_FLUSH,
	input wire logic              STORE_ORDER_WAIT,
	input wire logic              LINE_OBSERVED,
	input wire logic              SNOOP_RESP,
	// Outputs watched
	input wire logic              LOAD_HOLD,
	input wire logic              LOAD_OVERLAP_EVT,
	input wire logic              STORE_BUFFER_DRAIN_EVT,
	input wire logic              STORE_ORDER_EVT,
	input wire lsmon_pkg::count_t COUNT
);
	// Single domain, so clock and reset are given once
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	a_drain_level: assert property (STORE_BUFFER_DRAIN_EVT == (DRAIN_SERIALIZE
		| DRAIN_SYNC | DRAIN_INT_ACK | DRAIN_FLUSH)) else $error("drain level");
	a_drain_step: assert property (COUNT_EN && EVT_SEL == 8'h04
		&& UMASK_SEL == 8'h01 && STORE_BUFFER_DRAIN_EVT
		|=> COUNT == $past(COUNT) + 48'h1) else $error("drain count");
	a_order_step: assert property (COUNT_EN && EVT_SEL == 8'h04
		&& UMASK_SEL == 8'h02 && STORE_ORDER_EVT
		|=> COUNT == $past(COUNT) + 48'h1) else $error("order count");
	a_count_idle: assert property (!COUNT_EN |=> $stable(COUNT))
		else $error("count moved while disabled");
	a_hold_set: assert property (LOAD_OVERLAP_EVT |=> LOAD_HOLD)
		else $error("hold not set");
	a_hold_keep: assert property (LOAD_HOLD && !ST_COMMITTED |=> LOAD_HOLD)
		else $error("hold dropped early");
	a_order_set: assert property (STORE_ORDER_WAIT && !STORE_ORDER_EVT
		|=> STORE_ORDER_EVT) else $error("order stall not set");
	a_order_keep: assert property (STORE_ORDER_EVT && !LINE_OBSERVED
		&& !SNOOP_RESP |=> STORE_ORDER_EVT) else $error("order stall lost");
endmodule

// >>> dv/lsmon_top_test.sv
// Self-checking bench for the load/store event monitor
`timescale 1ns/1ns
module lsmon_top_test;
	import lsmon_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic   CLK, ARST_N, COUNT_EN, LD_VALID, LD_UNCACHEABLE, ST_VALID;
	logic   LD_PARTIAL_READ, ST_RETIRED, ST_COMMITTED, MISS_ALLOC;
	logic   MISS_DONE, LOCKED_LOAD, STORE_ORDER_WAIT, DRAIN_SERIALIZE;
	logic   DRAIN_SYNC, DRAIN_INT_ACK, DRAIN_FLUSH, LINE_OBSERVED;
	logic   NEEDS_BUS_READ, SNOOP_RESP, LOAD_HOLD, LOAD_OVERLAP_EVT;
	logic   LOAD_HELD_TO_RETIRE_EVT, LOAD_DCACHE_BLOCKED_EVT;
	logic   STORE_BUFFER_DRAIN_EVT, STORE_ORDER_EVT;
	code_t  EVT_SEL, UMASK_SEL;
	addr_t  LD_ADDR, ST_ADDR;
	size_t  LD_SIZE, ST_SIZE;
	count_t COUNT, c0;
	int     n_fail, n_compared;

	lsmon_top i_dut (.CLK, .ARST_N, .EVT_SEL, .UMASK_SEL, .COUNT_EN,
		.LD_VALID, .LD_ADDR, .LD_SIZE, .LD_UNCACHEABLE, .LD_PARTIAL_READ,
		.ST_VALID, .ST_ADDR, .ST_SIZE, .ST_RETIRED, .ST_COMMITTED,
		.MISS_ALLOC, .MISS_DONE, .LOCKED_LOAD, .DRAIN_SERIALIZE,
		.DRAIN_SYNC, .DRAIN_INT_ACK, .DRAIN_FLUSH, .STORE_ORDER_WAIT,
		.LINE_OBSERVED, .NEEDS_BUS_READ, .SNOOP_RESP, .LOAD_HOLD,
		.LOAD_OVERLAP_EVT, .LOAD_HELD_TO_RETIRE_EVT,
		.LOAD_DCACHE_BLOCKED_EVT, .STORE_BUFFER_DRAIN_EVT,
		.STORE_ORDER_EVT, .COUNT);

	// Clock, 10 ns period
	initial
	begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input count_t seen, input count_t exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Counter base is taken after the edge so no step is lost
	// Only the general-purpose counter is ever programmed here
	task sel(input code_t e, input code_t u, input logic en);
		@(posedge CLK);
		{EVT_SEL, UMASK_SEL, COUNT_EN} <= {e, u, en};
		#1 c0 = COUNT;
	endtask

	// Qualifier bits: uncacheable, partial read, locked
	task ld(input addr_t la, input size_t ls, input addr_t sa,
		input size_t ss, input logic [2:0] q);
		@(posedge CLK);
		{LD_VALID, ST_VALID, LD_ADDR, LD_SIZE} <= {2'b11, la, ls};
		{ST_ADDR, ST_SIZE} <= {sa, ss};
		{LD_UNCACHEABLE, LD_PARTIAL_READ, LOCKED_LOAD} <= q;
		#1;
	endtask

	task idle;
		@(posedge CLK) LD_VALID <= 1'b0;
		#1;
	endtask

	task miss(input int n, input logic done);
		repeat (n) @(posedge CLK) {MISS_ALLOC, MISS_DONE} <= {!done, done};
		@(posedge CLK) {MISS_ALLOC, MISS_DONE} <= 2'b00;
	endtask

	// Cause held over three sampling edges
	task drain(input logic [3:0] d);
		@(posedge CLK);
		{DRAIN_SERIALIZE, DRAIN_SYNC, DRAIN_INT_ACK, DRAIN_FLUSH} <= d;
		#1 chk(STORE_BUFFER_DRAIN_EVT, 1);
		repeat (3) @(posedge CLK);
		{DRAIN_SERIALIZE, DRAIN_SYNC, DRAIN_INT_ACK, DRAIN_FLUSH} <= 4'h0;
		#1;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_overlap;
		ld(48'h102, 5'd2, 48'h100, 5'd4, 3'b0);
		chk(LOAD_OVERLAP_EVT, 1);
		ld(48'h100, 5'd2, 48'h100, 5'd4, 3'b0);
		chk(LOAD_OVERLAP_EVT, 0);
		ld(48'h102, 5'd4, 48'h101, 5'd4, 3'b0);
		chk(LOAD_OVERLAP_EVT, 1);
		ld(48'h106, 5'd4, 48'h100, 5'd16, 3'b0);
		chk(LOAD_OVERLAP_EVT, 1);
		ld(48'h104, 5'd16, 48'h2000, 5'd4, 3'b0);
		chk(LOAD_OVERLAP_EVT, 0);
		ld(48'h1010, 5'd8, 48'h5010, 5'd8, 3'b0);
		chk(LOAD_OVERLAP_EVT, 1);
		idle;
	endtask

	// Retire alone must not free the load
	task t_hold;
		sel(8'h03, 8'h08, 1'b1);
		ld(48'h1010, 5'd8, 48'h5010, 5'd8, 3'b0);
		idle;
		chk(LOAD_HOLD, 1);
		chk(COUNT - c0, 1);
		@(posedge CLK) ST_RETIRED <= 1'b1;
		@(posedge CLK) ST_COMMITTED <= 1'b1;
		#1 chk(LOAD_HOLD, 1);
		@(posedge CLK) {ST_RETIRED, ST_COMMITTED} <= 2'b00;
		#1 chk(LOAD_HOLD, 0);
	endtask

	task t_retire;
		sel(8'h03, 8'h10, 1'b1);
		ld(48'h200, 5'd4, 48'h9000, 5'd4, 3'b100);
		chk(LOAD_HELD_TO_RETIRE_EVT, 1);
		ld(48'h23c, 5'd8, 48'h9000, 5'd4, 3'b000);
		chk(LOAD_HELD_TO_RETIRE_EVT, 1);
		chk(LOAD_DCACHE_BLOCKED_EVT, 1);
		ld(48'h200, 5'd4, 48'h9000, 5'd4, 3'b010);
		chk(LOAD_DCACHE_BLOCKED_EVT, 1);
		ld(48'h200, 5'd4, 48'h9000, 5'd4, 3'b001);
		chk(LOAD_DCACHE_BLOCKED_EVT, 1);
		ld(48'h200, 5'd4, 48'h9000, 5'd4, 3'b000);
		chk(LOAD_DCACHE_BLOCKED_EVT, 0);
		chk(LOAD_HELD_TO_RETIRE_EVT, 0);
		chk(COUNT - c0, 2);
	endtask

	// Limit of eight outstanding misses
	task t_miss;
		miss(7, 1'b0);
		ld(48'h200, 5'd4, 48'h9000, 5'd4, 3'b0);
		chk(LOAD_DCACHE_BLOCKED_EVT, 0);
		miss(1, 1'b0);
		ld(48'h200, 5'd4, 48'h9000, 5'd4, 3'b0);
		chk(LOAD_DCACHE_BLOCKED_EVT, 1);
		miss(1, 1'b1);
		ld(48'h200, 5'd4, 48'h9000, 5'd4, 3'b0);
		chk(LOAD_DCACHE_BLOCKED_EVT, 0);
		idle;
	endtask

	task t_drain;
		sel(8'h04, 8'h01, 1'b1);
		for (int i = 0; i < 4; i++)
			drain(4'b1000 >> i);
		chk(COUNT - c0, 12);
	endtask

	task t_select;
		sel(8'h03, 8'h01, 1'b1);
		drain(4'hf);
		chk(COUNT - c0, 0);
		sel(8'h04, 8'h01, 1'b0);
		drain(4'hf);
		chk(COUNT - c0, 0);
	endtask

	task t_order;
		sel(8'h04, 8'h02, 1'b1);
		@(posedge CLK) STORE_ORDER_WAIT <= 1'b1;
		@(posedge CLK) STORE_ORDER_WAIT <= 1'b0;
		repeat (3) @(posedge CLK);
		LINE_OBSERVED <= 1'b1;
		#1 chk(STORE_ORDER_EVT, 1);
		@(posedge CLK) LINE_OBSERVED <= 1'b0;
		#1 chk(STORE_ORDER_EVT, 0);
		@(posedge CLK) {STORE_ORDER_WAIT, NEEDS_BUS_READ} <= 2'b11;
		@(posedge CLK) {STORE_ORDER_WAIT, NEEDS_BUS_READ} <= 2'b00;
		@(posedge CLK) SNOOP_RESP <= 1'b1;
		#1 chk(STORE_ORDER_EVT, 1);
		@(posedge CLK) SNOOP_RESP <= 1'b0;
		#1 chk(STORE_ORDER_EVT, 0);
		chk(COUNT - c0, 6);
	endtask

	task close_out;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{ARST_N, COUNT_EN, LD_VALID, LD_UNCACHEABLE, LD_PARTIAL_READ} = '0;
		{ST_VALID, ST_RETIRED, ST_COMMITTED, MISS_ALLOC, MISS_DONE} = '0;
		{LOCKED_LOAD, DRAIN_SERIALIZE, DRAIN_SYNC, DRAIN_INT_ACK} = '0;
		{DRAIN_FLUSH, STORE_ORDER_WAIT, LINE_OBSERVED, SNOOP_RESP} = '0;
		{NEEDS_BUS_READ, EVT_SEL, UMASK_SEL, LD_ADDR, ST_ADDR} = '0;
		{LD_SIZE, ST_SIZE, n_fail, n_compared} = '0;
		repeat (10) @(posedge CLK);
		ARST_N <= 1'b1;
		#1 chk(COUNT, 0);
		t_overlap;
		t_hold;
		t_retire;
		t_miss;
		t_drain;
		t_select;
		t_order;
		close_out;
	end

	// Run needs under a hundred cycles; cut off well beyond that
	initial
	begin
		#20000;
		n_fail++;
		close_out;
	end
endmodule

bind lsmon_top lsmon_assertions i_chk (.CLK, .ARST_N, .EVT_SEL,
	.UMASK_SEL, .COUNT_EN, .ST_COMMITTED, .DRAIN_SERIALIZE, .DRAIN_SYNC,
	.DRAIN_INT_ACK, .DRAIN_FLUSH, .STORE_ORDER_WAIT, .LINE_OBSERVED,
	.SNOOP_RESP, .LOAD_HOLD, .LOAD_OVERLAP_EVT, .STORE_BUFFER_DRAIN_EVT,
	.STORE_ORDER_EVT, .COUNT);
